//--- sge_consts.svh
// offsets, field positions, reset values and widths of the six-pin gpio edge block
//
// Behaviour
// - six enable bits, one enables pin, reset zero
// - six direction bits, zero input, one output
// - output value bits act only on output pins
// - output pin drives value bit, resets low
// - rise detect enable per input pin, reset off
// - fall detect enable per input pin, reset off
// - sticky edge flags, cleared all on read unless set again by an edge in the same cycle
// - read-only sampled level of input pins
`ifndef SGE_CONSTS_SVH
`define SGE_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SGE_OFS_PIN_CTRL 8'h04
`define SGE_OFS_EDGE_EN 8'h05
`define SGE_OFS_IN_DATA 8'h06

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define SGE_NPINS 6
`define SGE_HI_LSB 16
`define SGE_MID_LSB 8
`define SGE_LO_LSB 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SGE_RST_BITS 6'h00
`define SGE_RST_WORD 24'h00_0000

`endif

//--- sge_pkg.sv
// types shared by the six-pin gpio edge block
package sge_pkg;
    typedef logic [5:0] sge_bits_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [23:0] wdata;
    } sge_req_type;

    typedef struct packed {
        sge_bits_type level;
        sge_bits_type rise;
        sge_bits_type fall;
    } sge_edge_type;
endpackage : sge_pkg

//--- sge_pin_sync.sv
// two-stage synchroniser and edge pulse detector for each gpio pin
`include "sge_consts.svh"
module sge_pin_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // raw pins and synchronised result
    input wire sge_pkg::sge_bits_type pin_in,
    output sge_pkg::sge_edge_type edges
);
    import sge_pkg::*;

    wire [5:0] level_bits;
    wire [5:0] rise_bits;
    wire [5:0] fall_bits;

    genvar gi;
    generate
        for (gi = 0; gi < `SGE_NPINS; gi = gi + 1) begin : g_pin
            logic meta_r;
            logic sync_r;
            logic prev_r;

            // meta_r feeds only sync_r
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_r <= 1'h0;
                    sync_r <= 1'h0;
                    prev_r <= 1'h0;
                end else begin
                    meta_r <= pin_in[gi];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            assign level_bits[gi] = sync_r;
            assign rise_bits[gi] = sync_r & ~prev_r;
            assign fall_bits[gi] = ~sync_r & prev_r;
        end
    endgenerate

    assign edges = '{level: level_bits, rise: rise_bits, fall: fall_bits};
endmodule : sge_pin_sync

//--- sge_gpio_top.sv
// six-pin gpio block with direction, drive and sticky edge detection
`include "sge_consts.svh"
module sge_gpio_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register access port
    input wire sge_pkg::sge_req_type reg_req,
    output logic [23:0] rd_data,
    output logic rd_valid,
    // gpio pins
    input wire sge_pkg::sge_bits_type gpio_in,
    output sge_pkg::sge_bits_type gpio_out,
    output sge_pkg::sge_bits_type gpio_oe_n
);
    import sge_pkg::*;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    sge_bits_type en_r;
    sge_bits_type dir_r;
    sge_bits_type outv_r;
    sge_bits_type rise_en_r;
    sge_bits_type fall_en_r;
    sge_bits_type rise_flags_r;
    sge_bits_type fall_flags_r;
    sge_bits_type rise_flags_nxt;
    sge_bits_type fall_flags_nxt;
    logic [23:0] rd_data_r;
    logic [23:0] rd_data_nxt;
    logic rd_valid_r;
    sge_bits_type gpio_out_r;
    sge_bits_type gpio_oe_n_r;
    sge_edge_type edges;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire sel_ctrl = reg_req.addr == `SGE_OFS_PIN_CTRL;
    wire sel_edge = reg_req.addr == `SGE_OFS_EDGE_EN;
    wire sel_data = reg_req.addr == `SGE_OFS_IN_DATA;
    wire wr_ctrl = reg_req.wr & sel_ctrl;
    wire wr_edge = reg_req.wr & sel_edge;
    wire rd_status = reg_req.rd & sel_data;
    wire [5:0] w_hi = reg_req.wdata[`SGE_HI_LSB +: `SGE_NPINS];
    wire [5:0] w_mid = reg_req.wdata[`SGE_MID_LSB +: `SGE_NPINS];
    wire [5:0] w_lo = reg_req.wdata[`SGE_LO_LSB +: `SGE_NPINS];

    // ----------------------------------------------------------------
    // pin input path
    // ----------------------------------------------------------------
    sge_pin_sync u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(gpio_in),
        .edges(edges)
    );

    // only enabled pins configured as inputs are watched
    wire [5:0] in_mask = en_r & ~dir_r;
    wire [5:0] lvl_bits = edges.level & in_mask;
    wire [5:0] rise_set = edges.rise & rise_en_r & in_mask;
    wire [5:0] fall_set = edges.fall & fall_en_r & in_mask;
    // a new edge wins over the read clear
    assign rise_flags_nxt = (rd_status ? `SGE_RST_BITS : rise_flags_r) | rise_set;
    assign fall_flags_nxt = (rd_status ? `SGE_RST_BITS : fall_flags_r) | fall_set;

    // ----------------------------------------------------------------
    // read mux; unmapped offsets read zero
    // ----------------------------------------------------------------
    wire [23:0] word_ctrl = {2'h0, en_r, 2'h0, dir_r, 2'h0, outv_r};
    wire [23:0] word_edge = {2'h0, rise_en_r, 2'h0, fall_en_r, 8'h00};
    wire [23:0] word_data = {2'h0, rise_flags_r, 2'h0, fall_flags_r, 2'h0, lvl_bits};
    assign rd_data_nxt = sel_ctrl ? word_ctrl :
                         sel_edge ? word_edge :
                         sel_data ? word_data : `SGE_RST_WORD;

    // ----------------------------------------------------------------
    // pin output path
    // ----------------------------------------------------------------
    wire [5:0] drive_mask = en_r & dir_r;
    wire [5:0] out_nxt = outv_r & drive_mask;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_r <= `SGE_RST_BITS;
            dir_r <= `SGE_RST_BITS;
            outv_r <= `SGE_RST_BITS;
        end else if (wr_ctrl) begin
            en_r <= w_hi;
            dir_r <= w_mid;
            outv_r <= w_lo;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rise_en_r <= `SGE_RST_BITS;
            fall_en_r <= `SGE_RST_BITS;
        end else if (wr_edge) begin
            rise_en_r <= w_hi;
            fall_en_r <= w_mid;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rise_flags_r <= `SGE_RST_BITS;
            fall_flags_r <= `SGE_RST_BITS;
        end else begin
            rise_flags_r <= rise_flags_nxt;
            fall_flags_r <= fall_flags_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_r <= `SGE_RST_WORD;
            rd_valid_r <= 1'h0;
        end else begin
            rd_valid_r <= reg_req.rd;
            if (reg_req.rd) begin
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gpio_out_r <= `SGE_RST_BITS;
            gpio_oe_n_r <= ~`SGE_RST_BITS;
        end else begin
            gpio_out_r <= out_nxt;
            gpio_oe_n_r <= ~drive_mask;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign gpio_out = gpio_out_r;
    assign gpio_oe_n = gpio_oe_n_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_ctrl_write_pins: assert property (
        wr_ctrl |-> ##2 gpio_oe_n == ~($past(w_hi, 2) & $past(w_mid, 2)))
        else $error("pin enables do not follow control write");

    a_input_not_driven: assert property (
        ((~dir_r & ~gpio_oe_n) == 6'h00) or $changed(dir_r))
        else $error("input pin is being driven");

    a_out_only_output: assert property (
        (gpio_out & ~$past(drive_mask)) == 6'h00)
        else $error("output value on pin not set as output");

    a_out_drive_value: assert property (
        wr_ctrl |-> ##2 (gpio_out == ($past(w_lo, 2) & $past(w_hi, 2) & $past(w_mid, 2))))
        else $error("driven level differs from output value");

    a_rise_sets_flag: assert property (
        (rise_set != 6'h00) |=> ((rise_flags_r & $past(rise_set)) == $past(rise_set)))
        else $error("enabled rising edge not flagged");

    a_fall_sets_flag: assert property (
        (fall_set != 6'h00) |=> ((fall_flags_r & $past(fall_set)) == $past(fall_set)))
        else $error("enabled falling edge not flagged");

    a_flag_needs_enable: assert property (
        ((rise_flags_r & ~$past(rise_flags_r)) & ~$past(rise_en_r & in_mask)) == 6'h00)
        else $error("rise flag set without enable");

    a_fall_needs_enable: assert property (
        ((fall_flags_r & ~$past(fall_flags_r)) & ~$past(fall_en_r & in_mask)) == 6'h00)
        else $error("fall flag set without enable");

    a_disabled_released: assert property (
        (~gpio_oe_n & ~$past(en_r)) == 6'h00)
        else $error("disabled pin is being driven");

    a_disabled_no_flags: assert property (
        ((rise_flags_r | fall_flags_r) & ~$past(rise_flags_r | fall_flags_r) & ~$past(en_r)) == 6'h00)
        else $error("edge flag set on disabled pin");

    a_flags_sticky: assert property (
        !rd_status |=> ((fall_flags_r & $past(fall_flags_r)) == $past(fall_flags_r))
                       and ((rise_flags_r & $past(rise_flags_r)) == $past(rise_flags_r)))
        else $error("edge flag lost without read");

    a_read_clears: assert property (
        (rd_status && rise_set == 6'h00 && fall_set == 6'h00) |=>
            (rise_flags_r == 6'h00 && fall_flags_r == 6'h00))
        else $error("status read did not clear flags");

    a_read_returns_flags: assert property (
        rd_status |=> rd_valid && rd_data[21:16] == $past(rise_flags_r)
                      && rd_data[13:8] == $past(fall_flags_r))
        else $error("status read returned wrong flags");

    a_level_two_stage: assert property (
        (!$past(sys_rst) && !$past(sys_rst, 2))
            |-> edges.level == $past(gpio_in, 2))
        else $error("synchronised level has wrong latency");

    a_level_report: assert property (
        rd_status |=> rd_data[5:0] == $past(edges.level & en_r & ~dir_r))
        else $error("input level read is wrong");

    a_edge_single: assert property (
        (edges.rise & $past(edges.rise)) == 6'h00)
        else $error("one transition gave two rise pulses");

    c_rise_flagged: cover property (rise_set != 6'h00 ##1 rd_status);
    c_fall_flagged: cover property (fall_set != 6'h00 ##[1:20] rd_status);
    c_set_on_clear: cover property (rd_status && rise_set != 6'h00);
    c_pin_driven: cover property (wr_ctrl ##2 gpio_oe_n != 6'h3f);
    c_level_read: cover property (rd_status && lvl_bits != 6'h00);
endmodule : sge_gpio_top

//--- sge_pin_model.sv
// external logic levels seen on the six gpio pins
module sge_pin_model (
    // device pin side
    input wire sge_pkg::sge_bits_type gpio_out,
    input wire sge_pkg::sge_bits_type gpio_oe_n,
    // level the outside world drives on released pins
    input wire sge_pkg::sge_bits_type ext_level,
    output sge_pkg::sge_bits_type gpio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import sge_pkg::*;
    // a driven pin shows the device value, a released pin the outside level
    assign gpio_in = (gpio_out & ~gpio_oe_n) | (ext_level & gpio_oe_n);
endmodule : sge_pin_model

//--- test_six_pin_gpio_edge_control.sv
// self-checking bench for the six-pin gpio edge block
module test_six_pin_gpio_edge_control;
    timeunit 1ns;
    timeprecision 1ps;
    import sge_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    sge_req_type reg_req = '0;
    logic [23:0] rd_data;
    logic rd_valid;
    sge_bits_type gpio_in, gpio_out, gpio_oe_n;
    sge_bits_type ext_level = 6'h00;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    sge_gpio_top sge_gpio_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .rd_data(rd_data), .rd_valid(rd_valid), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n));
    sge_pin_model sge_pin_model_inst (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .ext_level(ext_level), .gpio_in(gpio_in));

    always #2.5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_word(input string nm, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_word

    task automatic chk_pins(input string nm, input sge_bits_type exp, input sge_bits_type got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_pins

    task automatic chk_flag(input string nm, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_flag

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge ref_clk);
        reg_req.wr = 1'h1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(negedge ref_clk);
        reg_req.wr = 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        @(negedge ref_clk);
        reg_req.rd = 1'h1;
        reg_req.addr = a;
        @(negedge ref_clk);
        // rd_valid stands only in the cycle after the request edge, rd_data until the next read
        chk_flag("rd_valid", 1'h1, rd_valid);
        chk_word("rd_data", exp, rd_data);
        reg_req.rd = 1'h0;
    endtask : rd

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk_pins("oe_n at reset", 6'h3f, gpio_oe_n);
        chk_pins("out at reset", 6'h00, gpio_out);
        rd(8'h04, 24'h00_0000);
        rd(8'h05, 24'h00_0000);
        rd(8'h06, 24'h00_0000);
    endtask : t_reset

    task automatic t_ctrl;
        logic [23:0] tbl [3];
        logic [23:0] e;
        tbl = '{24'hff_ffff, 24'h0f_3c55, 24'h00_3f3f};
        foreach (tbl[i]) begin
            wr(8'h04, tbl[i]);
            @(negedge ref_clk);
            e = tbl[i] & 24'h3f_3f3f;
            chk_pins("gpio_out", e[5:0] & e[13:8] & e[21:16], gpio_out);
            chk_pins("gpio_oe_n", ~(e[13:8] & e[21:16]), gpio_oe_n);
            rd(8'h04, e);
        end
    endtask : t_ctrl

    task automatic t_edge_en;
        wr(8'h05, 24'hff_ffff);
        rd(8'h05, 24'h3f_3f00);
        wr(8'h05, 24'h12_21ff);
        rd(8'h05, 24'h12_2100);
        rd(8'h10, 24'h00_0000);
    endtask : t_edge_en

    task automatic t_edges;
        // pin 4 disabled, pin 5 output low, rise on all, fall on pins 0 1 4 5
        wr(8'h04, 24'h2f_2000);
        wr(8'h05, 24'h3f_3300);
        ext_level = 6'h3f;
        repeat (5) @(negedge ref_clk);
        ext_level = 6'h00;
        repeat (5) @(negedge ref_clk);
        ext_level = 6'h3f;
        repeat (5) @(negedge ref_clk);
        wr(8'h06, 24'hff_ffff);
        rd(8'h06, 24'h0f_030f);
        rd(8'h06, 24'h00_000f);
        wr(8'h05, 24'h00_0000);
        ext_level = 6'h05;
        repeat (5) @(negedge ref_clk);
        rd(8'h06, 24'h00_0005);
    endtask : t_edges

    task automatic t_mid_reset;
        // pins quiet during reset so the synchroniser sees no step at release
        ext_level = 6'h00;
        wr(8'h04, 24'h3f_3f3f);
        wr(8'h05, 24'h3f_3f00);
        @(negedge ref_clk);
        sys_rst = 1'h1;
        repeat (3) @(negedge ref_clk);
        chk_pins("oe_n in reset", 6'h3f, gpio_oe_n);
        chk_pins("out in reset", 6'h00, gpio_out);
        chk_flag("rd_valid in reset", 1'h0, rd_valid);
        sys_rst = 1'h0;
        @(negedge ref_clk);
        rd(8'h04, 24'h00_0000);
        rd(8'h05, 24'h00_0000);
        rd(8'h06, 24'h00_0000);
    endtask : t_mid_reset

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'h0;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_ctrl();
        t_edge_en();
        t_edges();
        t_mid_reset();
        print_verdict();
    end
endmodule : test_six_pin_gpio_edge_control
